// *** ldrm_pkg.sv ***
// Purpose: Shared constants for the LAN descriptor ring manager
// Assumes: 16-bit descriptor words, 24-bit buffer addresses
// Notes: Bit positions follow the descriptor word layouts
package ldrm_pkg;
  // ----------------------------------------
  // Descriptor field positions
  // ----------------------------------------
  localparam int OWN_BIT = 15;
  localparam int ERR_BIT = 14;
  localparam int RES_BIT = 13;
  localparam int MORE_BIT = 12;
  localparam int ONE_BIT = 11;
  localparam int DEFER_BIT = 10;
  localparam int FIRST_BIT = 9;
  localparam int LAST_BIT = 8;
  localparam int TX_BUFERR_BIT = 15;
  localparam int TX_UNDERFLOW_BIT = 14;
  localparam int TX_LATE_COL_BIT = 12;
  localparam int TX_CARRIER_LOSS_BIT = 11;
  localparam int TX_RETRY_ERR_BIT = 10;
  localparam int RX_OFLO_BIT = 12;
  localparam int RX_BUFERR_BIT = 10;
  localparam int RING_LEN_HI = 15;
  localparam int RING_LEN_LO = 13;
  localparam int CNT_W = 12;
  localparam int COL_DIST_W = 10;
  localparam int ADDR_W = 24;
  localparam int DESC_BYTES = 8;
  localparam logic [4:0] MAX_ATTEMPTS = 5'h10;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic [3:0] ONES_NIBBLE = 4'hF;
endpackage

// *** ldrm_ring_ptr.sv ***
// Purpose: Ring entry pointer with power-of-two wrap
// Assumes: Length code 0..7 gives 1..128 entries
// Notes: Entries are one quadword apart
module ldrm_ring_ptr
  import ldrm_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [2:0] len_code,
  input wire logic [ADDR_W-1:0] base,
  input wire logic load,
  input wire logic step,
  output logic [6:0] index,
  output logic [ADDR_W-1:0] entry_addr
);
  logic [7:0] size;
  logic [6:0] next_index;

  assign size = 8'(8'h01 << len_code);
  assign next_index = (8'({1'b0, index}) + 8'h01 >= size) ? 7'h00 : index + 7'h01;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      index <= 7'h00;
    else if (load)
      index <= 7'h00;
    else if (step)
      index <= next_index;
  end

  assign entry_addr = base + ADDR_W'({index, 3'h0});
endmodule

// *** ldrm_core.sv ***
// Purpose: Descriptor status generation for receive and transmit rings
// Assumes: Descriptor fetch/store engine outside consumes word outputs
// Notes: Events from the MAC are single-cycle pulses
module ldrm_core
  import ldrm_pkg::*;
(
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic INIT_DONE,
  input wire logic RECEIVER_DISABLE,
  input wire logic RETRY_DISABLE,
  input wire logic [15:0] RX_RING_POINTER,
  input wire logic [ADDR_W-1:0] RX_RING_BASE,
  input wire logic RX_PKT_START,
  input wire logic RX_BUF_DONE,
  input wire logic RX_PKT_END,
  input wire logic [CNT_W-1:0] RX_BYTE_COUNT,
  input wire logic RX_NEXT_OWNED,
  input wire logic RX_SILO_OVERFLOW,
  input wire logic [15:0] TX_DESC_WORD1_IN,
  input wire logic [15:0] TX_DESC_WORD1_NEXT,
  input wire logic TX_START,
  input wire logic CHANNEL_BUSY,
  input wire logic CARRIER_SENSE_INPUT,
  input wire logic COLLISION,
  input wire logic SLOT_ELAPSED,
  input wire logic SILO_EMPTY,
  input wire logic TX_BUF_END,
  input wire logic TX_FRAME_OK,
  output logic RECEIVER_ON_FLAG,
  output logic RX_ACCEPT,
  output logic RX_RING_STEP,
  output logic [ADDR_W-1:0] RX_ENTRY_ADDR,
  output logic [15:0] RX_DESC_WORD1,
  output logic [15:0] RX_DESC_WORD3,
  output logic RX_DESC_WRITE,
  output logic [15:0] TX_DESC_WORD1,
  output logic [15:0] TX_DESC_WORD3,
  output logic TX_DESC_WRITE,
  output logic TX_TRUNCATE,
  output logic TX_RETRY
);
  // ----------------------------------------
  // Receive ring pointer
  // ----------------------------------------
  logic [6:0] rx_index;
  logic [ADDR_W-1:0] rx_addr;
  logic rx_step;
  logic rx_in_pkt;
  logic rx_first;
  logic rx_buferr;
  logic rx_oflo;

  // Low three base bits are forced to zero; the host must align them anyway
  ldrm_ring_ptr u_rx_ptr (
    .clk(CLK),
    .reset_n(RESET_N),
    .len_code(RX_RING_POINTER[RING_LEN_HI:RING_LEN_LO]),
    .base({RX_RING_BASE[ADDR_W-1:3], 3'h0}),
    .load(INIT_DONE),
    .step(rx_step),
    .index(rx_index),
    .entry_addr(rx_addr)
  );

  assign rx_step = (RX_BUF_DONE || RX_PKT_END) && RECEIVER_ON_FLAG;

  // ----------------------------------------
  // Receiver enable
  // ----------------------------------------
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      RECEIVER_ON_FLAG <= 1'b0;
    else if (INIT_DONE)
      RECEIVER_ON_FLAG <= !RECEIVER_DISABLE;
  end

  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      RX_ACCEPT <= 1'b0;
      RX_RING_STEP <= 1'b0;
      RX_ENTRY_ADDR <= '0;
    end
    else
    begin
      RX_ACCEPT <= RECEIVER_ON_FLAG && !RECEIVER_DISABLE;
      RX_RING_STEP <= rx_step;
      RX_ENTRY_ADDR <= rx_addr;
    end
  end

  // ----------------------------------------
  // Receive descriptor status
  // ----------------------------------------
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      rx_in_pkt <= 1'b0;
      rx_first <= 1'b0;
      rx_buferr <= 1'b0;
      rx_oflo <= 1'b0;
      RX_DESC_WORD1 <= WORD_RESET;
      RX_DESC_WORD3 <= WORD_RESET;
      RX_DESC_WRITE <= 1'b0;
    end
    else
    begin
      RX_DESC_WRITE <= 1'b0;
      if (RX_PKT_START && RECEIVER_ON_FLAG)
      begin
        rx_in_pkt <= 1'b1;
        rx_first <= 1'b1;
        rx_buferr <= 1'b0;
        rx_oflo <= 1'b0;
      end
      else if (rx_in_pkt && RX_BUF_DONE && !RX_PKT_END)
      begin
        RX_DESC_WORD1 <= WORD_RESET;
        RX_DESC_WORD1[FIRST_BIT] <= rx_first;
        RX_DESC_WRITE <= 1'b1;
        rx_first <= 1'b0;
        // Next buffer not owned or silo overflow sets buffer error and overflow at once
        if (!RX_NEXT_OWNED || RX_SILO_OVERFLOW)
        begin
          RX_DESC_WORD1[ERR_BIT] <= 1'b1;
          RX_DESC_WORD1[RX_BUFERR_BIT] <= 1'b1;
          RX_DESC_WORD1[RX_OFLO_BIT] <= 1'b1;
          rx_buferr <= 1'b1;
          rx_oflo <= 1'b1;
        end
      end
      else if (rx_in_pkt && RX_PKT_END)
      begin
        rx_in_pkt <= 1'b0;
        RX_DESC_WORD1 <= WORD_RESET;
        RX_DESC_WORD1[FIRST_BIT] <= rx_first;
        RX_DESC_WORD1[LAST_BIT] <= 1'b1;
        RX_DESC_WORD1[ERR_BIT] <= rx_buferr || rx_oflo;
        RX_DESC_WORD1[RX_BUFERR_BIT] <= rx_buferr;
        RX_DESC_WORD1[RX_OFLO_BIT] <= rx_oflo;
        RX_DESC_WORD3 <= {4'h0, RX_BYTE_COUNT};
        RX_DESC_WRITE <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Transmit attempt tracking
  // ----------------------------------------
  logic [4:0] attempts;
  logic [COL_DIST_W-1:0] col_dist;
  logic tx_active;
  logic deferred;
  logic late_col;
  logic carrier_loss;
  logic underflow;
  logic buferr;
  logic retry_err;
  logic fatal;
  logic retry_limit;
  logic buf_fail;
  logic retry_go;
  logic tx_pending;

  assign fatal = late_col || carrier_loss || underflow || retry_err;
  assign retry_limit = RETRY_DISABLE || (attempts + 5'h01 >= MAX_ATTEMPTS);
  assign buf_fail = TX_BUF_END && !TX_DESC_WORD1_IN[LAST_BIT] && !TX_DESC_WORD1_NEXT[OWN_BIT];
  // Follows the branch order below, so a retried attempt never queues a write-back
  assign retry_go = tx_active && !buf_fail && !SILO_EMPTY && COLLISION && !SLOT_ELAPSED &&
    !retry_limit && !carrier_loss;

  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      tx_active <= 1'b0;
      attempts <= 5'h00;
      col_dist <= '0;
      deferred <= 1'b0;
      late_col <= 1'b0;
      carrier_loss <= 1'b0;
      underflow <= 1'b0;
      buferr <= 1'b0;
      retry_err <= 1'b0;
      TX_RETRY <= 1'b0;
      TX_TRUNCATE <= 1'b0;
    end
    else
    begin
      TX_RETRY <= 1'b0;
      TX_TRUNCATE <= 1'b0;
      if (TX_START && !tx_active)
      begin
        tx_active <= 1'b1;
        col_dist <= '0;
        // A write-back still in flight closes the last packet, so this is a first attempt
        if (attempts == 5'h00 || tx_pending || TX_DESC_WRITE)
        begin
          attempts <= 5'h00;
          deferred <= CHANNEL_BUSY;
          {late_col, carrier_loss, underflow, buferr, retry_err} <= 5'h00;
        end
      end
      else if (tx_active)
      begin
        if (col_dist != '1)
          col_dist <= col_dist + COL_DIST_W'(1);
        if (!CARRIER_SENSE_INPUT && !COLLISION)
          carrier_loss <= 1'b1;
        if (buf_fail)
        begin
          buferr <= 1'b1;
          underflow <= 1'b1;
          TX_TRUNCATE <= 1'b1;
          tx_active <= 1'b0;
        end
        else if (SILO_EMPTY)
        begin
          underflow <= 1'b1;
          TX_TRUNCATE <= 1'b1;
          tx_active <= 1'b0;
        end
        else if (COLLISION && SLOT_ELAPSED)
        begin
          late_col <= 1'b1;
          tx_active <= 1'b0;
        end
        else if (COLLISION)
        begin
          tx_active <= 1'b0;
          if (retry_limit)
            retry_err <= 1'b1;
          else
          begin
            attempts <= attempts + 5'h01;
            TX_RETRY <= !carrier_loss;
          end
        end
        else if (TX_FRAME_OK)
          tx_active <= 1'b0;
      end
      else if (TX_DESC_WRITE)
        attempts <= 5'h00;
    end
  end

  // ----------------------------------------
  // Transmit descriptor write-back
  // ----------------------------------------
  logic tx_done;
  assign tx_done = tx_active && (TX_FRAME_OK || SILO_EMPTY || COLLISION || buf_fail);

  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      tx_pending <= 1'b0;
    else
      tx_pending <= tx_done && !retry_go;
  end

  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      TX_DESC_WORD1 <= WORD_RESET;
      TX_DESC_WORD3 <= WORD_RESET;
      TX_DESC_WRITE <= 1'b0;
    end
    else
    begin
      TX_DESC_WRITE <= 1'b0;
      if (tx_pending && !TX_RETRY && !tx_active)
      begin
        TX_DESC_WORD1 <= TX_DESC_WORD1_IN;
        TX_DESC_WORD1[OWN_BIT] <= 1'b0;
        TX_DESC_WORD1[ERR_BIT] <= fatal;
        TX_DESC_WORD1[RES_BIT] <= 1'b0;
        TX_DESC_WORD1[MORE_BIT] <= !fatal && attempts > 5'h01;
        TX_DESC_WORD1[ONE_BIT] <= !fatal && attempts == 5'h01;
        TX_DESC_WORD1[DEFER_BIT] <= deferred;
        TX_DESC_WORD3 <= {buferr, underflow, 1'b0, late_col, carrier_loss, retry_err, col_dist};
        TX_DESC_WRITE <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  rx_on_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    INIT_DONE && RECEIVER_DISABLE |=> !RECEIVER_ON_FLAG)
    else $error("receiver on despite disable");
  rx_refuse_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    RECEIVER_DISABLE && !RECEIVER_ON_FLAG |=> !RX_ACCEPT && !RX_RING_STEP)
    else $error("receive activity while disabled");
  rx_oflo_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    RX_DESC_WRITE && RX_DESC_WORD1[RX_BUFERR_BIT] |-> RX_DESC_WORD1[RX_OFLO_BIT])
    else $error("buffer error without overflow");
  rx_buferr_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    rx_in_pkt && RX_BUF_DONE && !RX_PKT_END && !RX_PKT_START && !RX_NEXT_OWNED
    |=> RX_DESC_WRITE && RX_DESC_WORD1[RX_BUFERR_BIT])
    else $error("buffer error not flagged");
  rx_len_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    RX_DESC_WRITE |-> RX_DESC_WORD3[15:12] == 4'h0)
    else $error("message length upper bits set");
  tx_err_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    TX_DESC_WRITE |-> TX_DESC_WORD1[ERR_BIT] == (|TX_DESC_WORD3[TX_UNDERFLOW_BIT:TX_RETRY_ERR_BIT]))
    else $error("error summary mismatch");
  tx_own_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    TX_DESC_WRITE |-> !TX_DESC_WORD1[OWN_BIT] && !TX_DESC_WORD1[RES_BIT])
    else $error("ownership or reserved bit set");
  tx_underflow_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    tx_active && SILO_EMPTY && !TX_BUF_END |=> underflow && TX_TRUNCATE)
    else $error("underflow not flagged");
  tx_late_col_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    tx_active && COLLISION && SLOT_ELAPSED |=> !TX_RETRY)
    else $error("retry after late collision");
  tx_retry_err_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    tx_active && COLLISION && RETRY_DISABLE && !SILO_EMPTY && !SLOT_ELAPSED && !TX_BUF_END
    |=> retry_err)
    else $error("retry error missing with retry disabled");
  tx_retry_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    TX_DESC_WRITE |-> !(TX_DESC_WORD1[MORE_BIT] && TX_DESC_WORD1[ONE_BIT]))
    else $error("one and more both set");
endmodule

// *** ldrm_host_model.sv ***
// Purpose: Host side of the rings, supplying transmit descriptor words
// Assumes: Buffers are filled before ownership is handed over
// Notes: Words stay steady while the device owns them
module ldrm_host_model
  import ldrm_pkg::*;
(
  input wire logic last_buf,
  input wire logic next_own,
  output logic [15:0] word1_cur,
  output logic [15:0] word1_next,
  output logic [ADDR_W-1:0] ring_base,
  output logic [15:0] word2
);
  // Minimum-size buffer, its length given as a negative count
  assign word2 = {ONES_NIBBLE, 12'hFC0};
  // Quadword aligned, so the device never has to round the base
  assign ring_base = 24'h012340;
  // Handed over with ownership, first flag set and a fixed high address byte
  assign word1_cur = {1'b1, 5'h00, 1'b1, last_buf, 8'hA5};
  assign word1_next = {next_own, 15'h0300};
endmodule

// *** ldrm_core_bench.sv ***
// Purpose: Self-checking bench for the descriptor status core
// Assumes: Event inputs are one-cycle pulses driven 1 ns after the edge
// Notes: Words are compared under masks where a field is left open
module ldrm_core_bench
  import ldrm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLK = 1'b0, RESET_N = 1'b0, RECEIVER_DISABLE = 1'b0, RETRY_DISABLE = 1'b0;
  logic CHANNEL_BUSY = 1'b0, CARRIER_SENSE_INPUT = 1'b1, SLOT_ELAPSED = 1'b0;
  logic RX_NEXT_OWNED = 1'b1, RX_SILO_OVERFLOW = 1'b0, last_buf = 1'b1, next_own = 1'b1;
  logic [8:0] ev = 9'h000;
  logic [15:0] RX_RING_POINTER = 16'h2000;
  logic [CNT_W-1:0] RX_BYTE_COUNT = 12'h000;
  logic RECEIVER_ON_FLAG, RX_ACCEPT, RX_RING_STEP, RX_DESC_WRITE, TX_DESC_WRITE;
  logic TX_TRUNCATE, TX_RETRY;
  logic [ADDR_W-1:0] RX_ENTRY_ADDR, ring_base;
  logic [15:0] RX_DESC_WORD1, RX_DESC_WORD3, TX_DESC_WORD1, TX_DESC_WORD3;
  logic [15:0] word1_cur, word1_next, word2;
  int miscompares = 0, n_tests = 0, n_retry = 0, n_trunc = 0, n_rxw = 0;

  ldrm_host_model u_ldrm_host_model (.last_buf, .next_own, .word1_cur, .word1_next,
    .ring_base, .word2);
  ldrm_core u_ldrm_core (.CLK, .RESET_N, .INIT_DONE(ev[8]), .RECEIVER_DISABLE,
    .RETRY_DISABLE, .RX_RING_POINTER, .RX_RING_BASE(ring_base), .RX_PKT_START(ev[0]),
    .RX_BUF_DONE(ev[1]), .RX_PKT_END(ev[2]), .RX_BYTE_COUNT, .RX_NEXT_OWNED,
    .RX_SILO_OVERFLOW, .TX_DESC_WORD1_IN(word1_cur), .TX_DESC_WORD1_NEXT(word1_next),
    .TX_START(ev[3]), .CHANNEL_BUSY, .CARRIER_SENSE_INPUT, .COLLISION(ev[4]),
    .SLOT_ELAPSED, .SILO_EMPTY(ev[5]), .TX_BUF_END(ev[6]), .TX_FRAME_OK(ev[7]),
    .RECEIVER_ON_FLAG, .RX_ACCEPT, .RX_RING_STEP, .RX_ENTRY_ADDR, .RX_DESC_WORD1,
    .RX_DESC_WORD3, .RX_DESC_WRITE, .TX_DESC_WORD1, .TX_DESC_WORD3, .TX_DESC_WRITE,
    .TX_TRUNCATE, .TX_RETRY);

  always #2 CLK = ~CLK;

  always @(posedge CLK)
  begin
    if (TX_RETRY === 1'b1) n_retry++;
    if (TX_TRUNCATE === 1'b1) n_trunc++;
    if (RX_DESC_WRITE === 1'b1 || RX_RING_STEP === 1'b1) n_rxw++;
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic tick(input int n = 1);
    repeat (n) @(posedge CLK);
    #1;
  endtask

  task automatic pulse(input int k);
    ev[k] = 1'b1;
    tick();
    ev[k] = 1'b0;
  endtask

  function automatic logic seen(input int k);
    return k == 0 ? TX_RETRY === 1'b1 : k == 1 ? TX_DESC_WRITE === 1'b1 : RX_DESC_WRITE === 1'b1;
  endfunction

  // Bounded, so a missing answer shows up as a failed compare
  task automatic wait_hi(input int k);
    for (int i = 0; i < 8 && !seen(k); i++) tick();
  endtask

  task automatic chk(input logic ok, input string m);
    n_tests++;
    if (!ok)
    begin
      miscompares++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask

  task automatic stop_test();
    $display("compares %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic rx_ev(input int k, input logic [15:0] w1v);
    pulse(k);
    wait_hi(2);
    chk(RX_DESC_WRITE === 1'b1, "rx write");
    chk((RX_DESC_WORD1 & 16'h5700) === w1v, "rx word1 flags");
    if (k == 2) chk(RX_DESC_WORD3 === {4'h0, RX_BYTE_COUNT}, "rx length");
    tick();
  endtask

  task automatic rx_tests();
    pulse(8);
    tick(2);
    chk(RECEIVER_ON_FLAG === 1'b1 && RX_ENTRY_ADDR === ring_base, "rx start");
    chk(RX_ACCEPT === 1'b1, "rx accept");
    chk(word2[15:12] === 4'hF && (~word2[11:0] + 12'h001) >= 12'h040, "host word2");
    for (int p = 1; p < 4; p++)
    begin
      RX_BYTE_COUNT = 12'h040 + 12'(p);
      pulse(0);
      rx_ev(2, 16'h0300);
      tick(2);
      chk(RX_ENTRY_ADDR === ring_base + 24'(8 * (p % 2)), "ring entry");
    end
    pulse(0);
    rx_ev(1, 16'h0200);
    RX_BYTE_COUNT = 12'hFFF;
    rx_ev(2, 16'h0100);
    RX_NEXT_OWNED = 1'b0;
    pulse(0);
    rx_ev(1, 16'h5600);
    rx_ev(2, 16'h5500);
    RX_NEXT_OWNED = 1'b1;
    RX_SILO_OVERFLOW = 1'b1;
    pulse(0);
    rx_ev(1, 16'h5600);
    RX_SILO_OVERFLOW = 1'b0;
    rx_ev(2, 16'h5500);
    tick(2);
    RECEIVER_DISABLE = 1'b1;
    pulse(8);
    tick(2);
    chk(RECEIVER_ON_FLAG === 1'b0 && RX_ACCEPT === 1'b0, "receiver off");
    n_rxw = 0;
    pulse(0);
    pulse(2);
    tick(4);
    chk(n_rxw == 0, "disabled receiver wrote");
    RECEIVER_DISABLE = 1'b0;
    $display("receive tests done");
  endtask

  task automatic tx_case(input logic busy, input int nret, input int kind,
    input logic [15:0] w1m, input logic [15:0] w1v, input logic [15:0] w3v);
    n_retry = 0;
    n_trunc = 0;
    CHANNEL_BUSY = busy;
    for (int i = 0; i < nret; i++)
    begin
      pulse(3);
      CHANNEL_BUSY = 1'b0;
      tick(2);
      pulse(4);
      wait_hi(0);
      tick();
    end
    pulse(3);
    CHANNEL_BUSY = 1'b0;
    tick(2);
    SLOT_ELAPSED = kind == 1;
    CARRIER_SENSE_INPUT = kind != 5;
    tick();
    CARRIER_SENSE_INPUT = 1'b1;
    pulse(kind == 2 ? 5 : kind == 3 ? 6 : kind == 1 || kind >= 4 ? 4 : 7);
    SLOT_ELAPSED = 1'b0;
    wait_hi(1);
    chk(TX_DESC_WRITE === 1'b1, "tx write");
    chk((TX_DESC_WORD1 & w1m) === w1v, "tx word1");
    chk((TX_DESC_WORD3 & 16'hFC00) === w3v, "tx word3");
    chk(n_retry == nret, "retry count");
    if (kind == 2 || kind == 3) chk(n_trunc == 1, "truncate");
    if (kind == 4) chk(TX_DESC_WORD3[COL_DIST_W-1:0] === 10'h004, "distance");
    tick(2);
    $display("transmit case %0d done", kind);
  endtask

  initial
  begin
    #40000;
    miscompares++;
    $display("ERROR %0t watchdog expired", $time);
    stop_test();
  end

  initial
  begin
    tick(4);
    RESET_N = 1'b1;
    tick();
    rx_tests();
    tx_case(1'b1, 1, 0, 16'hFFFF, 16'h0FA5, 16'h0000);
    tx_case(1'b0, 2, 0, 16'hFFFF, 16'h13A5, 16'h0000);
    RETRY_DISABLE = 1'b1;
    tx_case(1'b0, 0, 4, 16'hE3FF, 16'h43A5, 16'h0400);
    RETRY_DISABLE = 1'b0;
    tx_case(1'b0, 15, 4, 16'hE3FF, 16'h43A5, 16'h0400);
    tx_case(1'b0, 0, 1, 16'hE3FF, 16'h43A5, 16'h1000);
    tx_case(1'b0, 0, 5, 16'hE3FF, 16'h43A5, 16'h0800);
    tx_case(1'b0, 0, 2, 16'hE3FF, 16'h43A5, 16'h4000);
    last_buf = 1'b0;
    next_own = 1'b0;
    tx_case(1'b0, 0, 3, 16'hE3FF, 16'h42A5, 16'hC000);
    stop_test();
  end
endmodule
